// *** rtl/stm_params.svh ***
`ifndef STM_PARAMS_SVH
`define STM_PARAMS_SVH

// Register byte addresses
`define STM_ADDR_CTRL 8'h00
`define STM_ADDR_CMPA 8'h04
`define STM_ADDR_CMPP 8'h08
`define STM_ADDR_COUNT 8'h0C
`define STM_ADDR_STATUS 8'h10

// Control register field positions
`define STM_CTRL_CCLR 0
`define STM_CTRL_DPX 1
`define STM_CTRL_POL 2
`define STM_CTRL_OC 3
`define STM_CTRL_IO_LO 4
`define STM_CTRL_IO_HI 5
`define STM_CTRL_MODE_LO 6
`define STM_CTRL_MODE_HI 7
`define STM_CTRL_RUN 8

// Status register field positions
`define STM_STAT_MATCH_A 0
`define STM_STAT_MATCH_P 1

// Reset values
`define STM_CMPA_RST 16'h0000
`define STM_CMPP_RST 8'h00
`define STM_COUNT_RST 16'h0000
`define STM_RDATA_RST 32'h0000_0000

// Output-function codes, compare-match output mode
`define STM_IO_NOCHANGE 2'h0
`define STM_IO_LOW 2'h1
`define STM_IO_HIGH 2'h2
`define STM_IO_TOGGLE 2'h3

// Output-function codes, PWM / single-pulse mode
`define STM_IO_FORCE_INACTIVE 2'h0
`define STM_IO_FORCE_ACTIVE 2'h1
`define STM_IO_PWM 2'h2
`define STM_IO_PULSE 2'h3

// Output-function codes, capture mode
`define STM_IO_CAP_RISE 2'h0
`define STM_IO_CAP_FALL 2'h1
`define STM_IO_CAP_BOTH 2'h2
`define STM_IO_CAP_OFF 2'h3

// Comparator P matches at the last count of a 256-count block
`define STM_P_LOW_FILL 8'hFF
`define STM_P_STEP 8'h01

`endif

// *** rtl/stm_pkg.sv ***
package stm_pkg;

  localparam int STM_CNT_W = 16;
  localparam int STM_CMPP_W = 8;

  typedef enum logic [1:0] {
    STM_MODE_COMPARE = 2'b00,
    STM_MODE_CAPTURE = 2'b01,
    STM_MODE_PWM = 2'b10,
    STM_MODE_TIMER = 2'b11
  } stm_mode_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
    logic rise;
    logic fall;
  } stm_sync_state_t;

  typedef struct packed {
    stm_mode_t mode;
    logic [1:0] io;
    logic oc;
    logic pol;
    logic dpx;
    logic cclr;
    logic run;
    logic [STM_CNT_W-1:0] cmp_a;
    logic [STM_CMPP_W-1:0] cmp_p;
    logic [STM_CNT_W-1:0] count;
    logic flag_a;
    logic flag_p;
    logic cmp_level;
    logic pin_out;
    logic pin_oe;
    logic waitreq;
    logic [31:0] rdata;
  } stm_core_state_t;

endpackage : stm_pkg

// *** rtl/stm_pin_sync.sv ***
// Three-stage pin synchroniser; a change is taken once stages two and three agree
module stm_pin_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);
  import stm_pkg::*;

  stm_sync_state_t s_reg;
  stm_sync_state_t s_next;

  always_comb begin
    s_next = s_reg;
    s_next.s1 = pin;
    s_next.s2 = s_reg.s1;
    s_next.s3 = s_reg.s2;
    s_next.rise = 1'b0;
    s_next.fall = 1'b0;
    if ((s_reg.s2 == s_reg.s3) && (s_reg.s3 != s_reg.level)) begin
      s_next.level = s_reg.s3;
      s_next.rise = s_reg.s3;
      s_next.fall = ~s_reg.s3;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign level = s_reg.level;
  assign rise = s_reg.rise;
  assign fall = s_reg.fall;

endmodule : stm_pin_sync

// *** rtl/stm_core.sv ***
// Behaviour
// - Clear-select low: clear on P match, or overflow when P is zero; both flags.
// - Clear-select high: clear on A match, raise only the A flag.
// - Compare mode pin changes only on an A match or run rising; P matches leave it alone.
// - On A match the output function drives high, low, toggles, or nothing.
// - Compare output codes: 00 none, 01 low, 10 high, 11 toggle.
// - Run bit rising loads the pin with the output-level bit.
// - Mode 11 counts and flags like compare mode but never drives the pin.
// - PWM ignores clear-select; swap bit picks which comparator sets period or duty.
// - PWM raises a separate flag for every A match and every P match.
// - PWM active level from output-level bit; codes 00/01 force pin, PWM keeps running.
// - Invert bit inverts the waveform on the timer pin.
// - Run bit rising starts count and pulse; in single pulse a trigger pin rising edge sets run bit.
// - Single pulse: A match clears run bit, ends pulse, raises flag; software clear too.
// - Single pulse: counter zeroed only on run rising; P, clear-select, swap unused.
// - Capture codes: 00 rising, 01 falling, 10 both, 11 disabled.
// - Each selected pin edge copies the counter into compare A and raises a flag.
// - Capture: counter free-runs until run falls; P match zeroes it and flags.
// - Capture code 11 stops captures while the counter keeps running.
`include "stm_params.svh"

module stm_core (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic TIMER_PIN_ZERO_IN,
  output logic TIMER_PIN_ZERO_OUT,
  output logic TIMER_PIN_ZERO_OE,
  input wire logic EXTERNAL_TRIGGER_PIN
);
  import stm_pkg::*;

  stm_core_state_t s_reg;
  stm_core_state_t s_next;

  logic pin_rise;
  logic pin_fall;
  logic trig_rise;

  // Byte-lane merge of a write into an existing word
  function automatic logic [31:0] lane_merge(
    input logic [31:0] old_val,
    input logic [31:0] new_val,
    input logic [3:0] be
  );
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return res;
  endfunction : lane_merge

  // Packs the control fields into their register layout
  function automatic logic [31:0] ctrl_word(input stm_core_state_t st);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`STM_CTRL_CCLR] = st.cclr;
    w[`STM_CTRL_DPX] = st.dpx;
    w[`STM_CTRL_POL] = st.pol;
    w[`STM_CTRL_OC] = st.oc;
    w[`STM_CTRL_IO_HI:`STM_CTRL_IO_LO] = st.io;
    w[`STM_CTRL_MODE_HI:`STM_CTRL_MODE_LO] = st.mode;
    w[`STM_CTRL_RUN] = st.run;
    return w;
  endfunction : ctrl_word

  // Read decode; unmapped addresses return zero
  function automatic logic [31:0] read_mux(
    input stm_core_state_t st,
    input logic [7:0] addr
  );
    logic [31:0] w;
    w = 32'h0000_0000;
    case (addr)
      `STM_ADDR_CTRL: begin
        w = ctrl_word(st);
      end
      `STM_ADDR_CMPA: begin
        w[STM_CNT_W-1:0] = st.cmp_a;
      end
      `STM_ADDR_CMPP: begin
        w[STM_CMPP_W-1:0] = st.cmp_p;
      end
      `STM_ADDR_COUNT: begin
        w[STM_CNT_W-1:0] = st.count;
      end
      `STM_ADDR_STATUS: begin
        w[`STM_STAT_MATCH_A] = st.flag_a;
        w[`STM_STAT_MATCH_P] = st.flag_p;
      end
      default: begin
        w = 32'h0000_0000;
      end
    endcase
    return w;
  endfunction : read_mux

  stm_pin_sync u_cap_sync (
    .clk(MCLK),
    .rst_n(RST_N),
    .ce(CE),
    .pin(TIMER_PIN_ZERO_IN),
    .level(),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  stm_pin_sync u_trig_sync (
    .clk(MCLK),
    .rst_n(RST_N),
    .ce(CE),
    .pin(EXTERNAL_TRIGGER_PIN),
    .level(),
    .rise(trig_rise),
    .fall()
  );

  always_comb begin
    logic bus_req;
    logic wr_go;
    logic [31:0] wmerged;
    logic clr_flag_a;
    logic clr_flag_p;
    logic run_rise;
    logic single_pulse;
    logic [STM_CNT_W-1:0] p_match_val;
    logic match_a;
    logic match_p;
    logic clr_count;
    logic set_a;
    logic set_p;
    logic cap_edge;
    logic duty_active;
    logic lvl;

    s_next = s_reg;
    bus_req = AVS_READ | AVS_WRITE;
    wr_go = AVS_WRITE & ~s_reg.waitreq;
    single_pulse = (s_reg.mode == STM_MODE_PWM) && (s_reg.io == `STM_IO_PULSE);
    // Comparators look at the counter only while it runs, so a held count
    // cannot keep re-raising a flag after the counter stops.
    // overflow when P is zero
    p_match_val = {s_reg.cmp_p - `STM_P_STEP, `STM_P_LOW_FILL};
    match_a = s_reg.run && (s_reg.count == s_reg.cmp_a);
    match_p = s_reg.run && (s_reg.count == p_match_val);
    run_rise = 1'b0;
    wmerged = 32'h0000_0000;
    clr_flag_a = 1'b0;
    clr_flag_p = 1'b0;
    clr_count = 1'b0;
    set_a = 1'b0;
    set_p = 1'b0;
    cap_edge = 1'b0;
    duty_active = 1'b0;
    lvl = 1'b0;

    // One wait cycle per access, then a single ready cycle
    s_next.waitreq = ~(bus_req & s_reg.waitreq);
    if (AVS_READ && s_reg.waitreq) begin
      s_next.rdata = read_mux(s_reg, AVS_ADDRESS);
    end

    if (wr_go) begin
      case (AVS_ADDRESS)
        `STM_ADDR_CTRL: begin
          wmerged = lane_merge(ctrl_word(s_reg), AVS_WRITEDATA, AVS_BYTEENABLE);
          s_next.cclr = wmerged[`STM_CTRL_CCLR];
          s_next.dpx = wmerged[`STM_CTRL_DPX];
          s_next.pol = wmerged[`STM_CTRL_POL];
          s_next.oc = wmerged[`STM_CTRL_OC];
          s_next.io = wmerged[`STM_CTRL_IO_HI:`STM_CTRL_IO_LO];
          s_next.mode = stm_mode_t'(wmerged[`STM_CTRL_MODE_HI:`STM_CTRL_MODE_LO]);
          s_next.run = wmerged[`STM_CTRL_RUN];
        end
        `STM_ADDR_CMPA: begin
          wmerged = lane_merge({16'h0000, s_reg.cmp_a}, AVS_WRITEDATA, AVS_BYTEENABLE);
          s_next.cmp_a = wmerged[STM_CNT_W-1:0];
        end
        `STM_ADDR_CMPP: begin
          wmerged = lane_merge({24'h00_0000, s_reg.cmp_p}, AVS_WRITEDATA, AVS_BYTEENABLE);
          s_next.cmp_p = wmerged[STM_CMPP_W-1:0];
        end
        `STM_ADDR_STATUS: begin
          clr_flag_a = AVS_BYTEENABLE[0] & AVS_WRITEDATA[`STM_STAT_MATCH_A];
          clr_flag_p = AVS_BYTEENABLE[0] & AVS_WRITEDATA[`STM_STAT_MATCH_P];
        end
        default: begin
          wmerged = 32'h0000_0000;
        end
      endcase
    end

    case (s_reg.mode)
      STM_MODE_COMPARE, STM_MODE_TIMER: begin
        if (s_reg.cclr) begin
          clr_count = match_a;
          set_a = match_a;
        end else begin
          clr_count = match_p;
          set_a = match_a;
          set_p = match_p;
        end
      end
      STM_MODE_PWM: begin
        if (single_pulse) begin
          set_a = match_a;
          if (match_a) begin
            s_next.run = 1'b0;
          end
        end else begin
          clr_count = s_reg.dpx ? match_a : match_p;
          set_a = match_a;
          set_p = match_p;
        end
      end
      STM_MODE_CAPTURE: begin
        clr_count = match_p;
        set_p = match_p;
        case (s_reg.io)
          `STM_IO_CAP_RISE: begin
            cap_edge = pin_rise;
          end
          `STM_IO_CAP_FALL: begin
            cap_edge = pin_fall;
          end
          `STM_IO_CAP_BOTH: begin
            cap_edge = pin_rise | pin_fall;
          end
          default: begin
            cap_edge = 1'b0;
          end
        endcase
        if (cap_edge) begin
          s_next.cmp_a = s_reg.count;
          set_a = 1'b1;
        end
      end
      default: begin
        clr_count = 1'b0;
      end
    endcase

    if (single_pulse && trig_rise) begin
      s_next.run = 1'b1;
    end
    // Set wins over a same-cycle software clear
    s_next.flag_a = (s_reg.flag_a & ~clr_flag_a) | set_a;
    s_next.flag_p = (s_reg.flag_p & ~clr_flag_p) | set_p;
    run_rise = s_next.run & ~s_reg.run;

    if (run_rise) begin
      s_next.count = `STM_COUNT_RST;
    end else if (s_reg.run && s_next.run) begin
      s_next.count = clr_count ? `STM_COUNT_RST : s_reg.count + 16'h0001;
    end

    if (run_rise) begin
      s_next.cmp_level = s_next.oc;
    end else if ((s_reg.mode == STM_MODE_COMPARE) && match_a) begin
      case (s_reg.io)
        `STM_IO_LOW: begin
          s_next.cmp_level = 1'b0;
        end
        `STM_IO_HIGH: begin
          s_next.cmp_level = 1'b1;
        end
        `STM_IO_TOGGLE: begin
          s_next.cmp_level = ~s_reg.cmp_level;
        end
        default: begin
          s_next.cmp_level = s_reg.cmp_level;
        end
      endcase
    end

    if (s_next.dpx) begin
      duty_active = s_next.count[STM_CNT_W-1:STM_CNT_W-STM_CMPP_W] < s_next.cmp_p;
    end else begin
      duty_active = s_next.count < s_next.cmp_a;
    end

    case (s_next.mode)
      STM_MODE_COMPARE: begin
        lvl = s_next.cmp_level;
        s_next.pin_oe = 1'b1;
      end
      STM_MODE_PWM: begin
        case (s_next.io)
          `STM_IO_FORCE_INACTIVE: begin
            lvl = ~s_next.oc;
          end
          `STM_IO_FORCE_ACTIVE: begin
            lvl = s_next.oc;
          end
          `STM_IO_PWM: begin
            lvl = duty_active ? s_next.oc : ~s_next.oc;
          end
          default: begin
            lvl = s_next.run ? s_next.oc : ~s_next.oc;
          end
        endcase
        s_next.pin_oe = 1'b1;
      end
      default: begin
        // pin released in timer and capture modes
        lvl = 1'b0;
        s_next.pin_oe = 1'b0;
      end
    endcase
    s_next.pin_out = s_next.pin_oe & (lvl ^ s_next.pol);
  end

  // CE low freezes everything, the bus handshake included
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      s_reg <= '0;
      s_reg.mode <= STM_MODE_COMPARE;
      s_reg.cmp_a <= `STM_CMPA_RST;
      s_reg.cmp_p <= `STM_CMPP_RST;
      s_reg.count <= `STM_COUNT_RST;
      s_reg.rdata <= `STM_RDATA_RST;
      s_reg.waitreq <= 1'b1;
    end else if (CE) begin
      s_reg <= s_next;
    end
  end

  assign AVS_READDATA = s_reg.rdata;
  assign AVS_WAITREQUEST = s_reg.waitreq;
  assign TIMER_PIN_ZERO_OUT = s_reg.pin_out;
  assign TIMER_PIN_ZERO_OE = s_reg.pin_oe;

endmodule : stm_core

// *** sim/stm_core_chk.sv ***
module stm_core_chk (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  input wire logic TIMER_PIN_ZERO_OUT,
  input wire logic TIMER_PIN_ZERO_OE
);
  // Shadow of mode, io, oc, pol; age lets the registered pin settle after a write
  logic [5:0] ctl_reg;
  logic [1:0] age_reg;
  logic ctl_wr;
  assign ctl_wr = AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == 8'h00;
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      ctl_reg <= 6'h00;
      age_reg <= 2'h0;
    end else if (ctl_wr) begin
      ctl_reg <= AVS_WRITEDATA[7:2];
      age_reg <= 2'h0;
    end else if (age_reg != 2'h3) begin
      age_reg <= age_reg + 2'h1;
    end
  end
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  a_wait_one: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("waitrequest not low one cycle after request");
  a_unmapped_zero: assert property (AVS_READ && !AVS_WAITREQUEST
    && !(AVS_ADDRESS inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10}) |-> AVS_READDATA == 32'h0)
    else $error("unmapped read not zero");
  a_idle_low: assert property (!TIMER_PIN_ZERO_OE |-> !TIMER_PIN_ZERO_OUT)
    else $error("pin level high while released");
  a_timer_no_drive: assert property (ctl_reg[5:4] == 2'b11 && age_reg == 2'h3 |-> !TIMER_PIN_ZERO_OE)
    else $error("pin driven in timer mode");
  a_capture_no_drive: assert property (ctl_reg[5:4] == 2'b01 && age_reg == 2'h3 |-> !TIMER_PIN_ZERO_OE)
    else $error("pin driven in capture mode");
  a_cmp_hold: assert property (ctl_reg[5:2] == 4'h0 && age_reg == 2'h3 |-> $stable(TIMER_PIN_ZERO_OUT))
    else $error("pin moved with no-change code");
  a_cmp_high_only: assert property (ctl_reg[5:2] == 4'h2 && !ctl_reg[0] && age_reg == 2'h3
    |-> !$fell(TIMER_PIN_ZERO_OUT))
    else $error("pin fell with drive-high code");
  a_cmp_low_only: assert property (ctl_reg[5:2] == 4'h1 && !ctl_reg[0] && age_reg == 2'h3
    |-> !$rose(TIMER_PIN_ZERO_OUT))
    else $error("pin rose with drive-low code");
  a_pwm_force: assert property (ctl_reg[5:3] == 3'b100 && age_reg == 2'h3
    |-> TIMER_PIN_ZERO_OUT == ((ctl_reg[2] ? ctl_reg[1] : !ctl_reg[1]) ^ ctl_reg[0]))
    else $error("forced pwm level wrong");
  c_pwm: cover property (ctl_reg[5:2] == 4'hA && age_reg == 2'h3);
  c_capture: cover property (ctl_reg[5:4] == 2'b01 && age_reg == 2'h3);
  c_cmp_rise: cover property (ctl_reg[5:4] == 2'b00 && $rose(TIMER_PIN_ZERO_OUT));
endmodule : stm_core_chk

// *** sim/stm_pin_model.sv ***
module stm_pin_model (
  input wire logic clk,
  input wire logic oe,
  input wire logic out,
  input wire logic drv,
  input wire logic fire,
  output logic pin,
  output logic trig
);
  timeunit 1ns;
  timeprecision 1ps;
  // Drives the pin only while released
  assign pin = oe ? out : drv;
  initial trig = 1'b0;
  // Trigger changes just after an edge
  always @(posedge clk) trig <= fire;
endmodule : stm_pin_model

// *** sim/stm_core_bench.sv ***
`include "stm_params.svh"
module stm_core_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst_n, ce, rd, wr, wreq, pin_out, pin_oe, pin_in, trig, drv, fire, oc, pol;
  logic [7:0] addr;
  logic [3:0] be;
  logic [31:0] wdata, rdata, r;
  logic [15:0] a;
  int fails, n_tests, cyc, i, e, k, per;
  stm_core uut (.MCLK(mclk), .RST_N(rst_n), .CE(ce), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wreq),
    .TIMER_PIN_ZERO_IN(pin_in), .TIMER_PIN_ZERO_OUT(pin_out), .TIMER_PIN_ZERO_OE(pin_oe),
    .EXTERNAL_TRIGGER_PIN(trig));
  stm_pin_model far (.clk(mclk), .oe(pin_oe), .out(pin_out), .drv(drv), .fire(fire), .pin(pin_in), .trig(trig));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 90000) begin
      fails++;
      wrap_up();
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Holds the request until waitrequest is sampled low at a rising edge; data is taken at that edge
  task xfer(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge mclk);
    addr <= ad;
    wdata <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge mclk);
    end while (wreq !== 1'b0);
    r = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : xfer
  task poll(input int b);
    r = 32'h0;
    for (k = 0; k < 40000 && r[b] !== 1'b1; k++) xfer(1'b0, `STM_ADDR_STATUS, 32'h0);
  endtask : poll
  function automatic logic [31:0] cw(logic run, logic [1:0] m, logic [1:0] io, logic c, logic p, logic x, logic cl);
    return {23'h0, run, m, io, c, p, x, cl};
  endfunction : cw
  function automatic logic cmp_pin(logic [1:0] io, logic c);
    return io == `STM_IO_NOCHANGE ? c : io == `STM_IO_LOW ? 1'b0 : io == `STM_IO_HIGH ? 1'b1 : !c;
  endfunction : cmp_pin
  function automatic logic cap_hit(logic [1:0] io, logic rising);
    return io == `STM_IO_CAP_BOTH || (io == `STM_IO_CAP_RISE && rising) || (io == `STM_IO_CAP_FALL && !rising);
  endfunction : cap_hit
  task setup(input logic [31:0] c, input logic [15:0] av, input logic [7:0] pv);
    xfer(1'b1, `STM_ADDR_CTRL, c);
    xfer(1'b1, `STM_ADDR_CMPA, {16'h0, av});
    xfer(1'b1, `STM_ADDR_CMPP, {24'h0, pv});
    xfer(1'b1, `STM_ADDR_STATUS, 32'h3);
  endtask : setup
  initial begin
    {rst_n, rd, wr, addr, wdata, drv, fire, fails, n_tests, cyc} = '0;
    ce = 1'b1;
    be = 4'hF;
    void'($urandom(71930));
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    xfer(1'b1, 8'h14, 32'hFFFFFFFF);
    for (i = 0; i < 6; i++) begin
      xfer(1'b0, 8'(i * 4), 32'h0);
      chk(r, 32'h0);
    end
    chk(pin_oe, 1'b1);
    $display("test reset done");
    for (i = 0; i < 4; i++) begin
      a = 16'(256 + $urandom_range(63));
      oc = 1'($urandom_range(1));
      // Compare A kept nonzero, above P
      setup(cw(0, 2'b00, i[1:0], oc, 0, 0, 1), a, 8'h01);
      xfer(1'b1, `STM_ADDR_CTRL, cw(1, 2'b00, i[1:0], oc, 0, 0, 1));
      repeat (2) @(negedge mclk);
      chk(pin_out, oc);
      poll(0);
      chk(pin_out, cmp_pin(i[1:0], oc));
      chk(r[1], 1'b0);
    end
    for (i = 0; i < 2; i++) begin
      setup(cw(0, 2'b00, 2'b10, 0, 0, 0, 0), 16'($urandom_range(8, 200)), 8'(1 - i));
      xfer(1'b1, `STM_ADDR_CTRL, cw(1, 2'b00, 2'b10, 0, 0, 0, 0));
      poll(1);
      chk(r[0], 1'b1);
      chk(pin_out, 1'b1);
      xfer(1'b0, `STM_ADDR_COUNT, 32'h0);
      chk(r[15:8], 8'h00);
    end
    setup(cw(0, 2'b11, 0, 0, 0, 0, 1), 16'd20, 8'h01);
    xfer(1'b1, `STM_ADDR_CTRL, cw(1, 2'b11, 0, 0, 0, 0, 1));
    poll(0);
    chk(r[1], 1'b0);
    chk(pin_oe, 1'b0);
    $display("test compare done");
    for (i = 0; i < 2; i++) begin
      pol = 1'($urandom_range(1));
      a = i ? 16'd511 : 16'($urandom_range(20, 200));
      per = i ? 512 : 256;
      setup(cw(0, 2'b10, 2'b10, 1, pol, i[0], 1), a, 8'h01);
      xfer(1'b1, `STM_ADDR_CTRL, cw(1, 2'b10, 2'b10, 1, pol, i[0], 1));
      repeat (per) @(negedge mclk);
      e = 0;
      repeat (per) begin
        @(negedge mclk);
        if (pin_out === !pol) e++;
      end
      chk(e, i ? 256 : int'(a));
      xfer(1'b0, `STM_ADDR_STATUS, 32'h0);
      chk(r[1:0], 2'b11);
      xfer(1'b1, `STM_ADDR_CTRL, cw(1, 2'b10, {1'b0, i[0]}, 1, pol, i[0], 1));
      repeat (3) @(negedge mclk);
      chk(pin_out, i[0] ^ pol);
    end
    a = 16'($urandom_range(10, 60));
    setup(cw(0, 2'b10, 2'b11, 1, 0, 0, 0), a, 8'h00);
    @(posedge mclk);
    fire <= 1'b1;
    e = 0;
    repeat (120) begin
      @(negedge mclk);
      if (pin_out === 1'b1) e++;
    end
    chk(e, int'(a) + 1);
    xfer(1'b0, `STM_ADDR_CTRL, 32'h0);
    chk(r[8], 1'b0);
    xfer(1'b0, `STM_ADDR_COUNT, 32'h0);
    chk(r, {16'h0, a});
    xfer(1'b0, `STM_ADDR_STATUS, 32'h0);
    chk(r[0], 1'b1);
    fire <= 1'b0;
    $display("test pwm and pulse done");
    // P match every 256 counts keeps captured values below 256
    xfer(1'b1, `STM_ADDR_CMPP, 32'h1);
    for (i = 0; i < 4; i++) begin
      xfer(1'b1, `STM_ADDR_CTRL, cw(1, 2'b01, i[1:0], 0, 0, 0, 0));
      for (e = 0; e < 2; e++) begin
        xfer(1'b1, `STM_ADDR_CMPA, 32'hFFFF);
        xfer(1'b1, `STM_ADDR_STATUS, 32'h3);
        @(posedge mclk);
        drv <= !drv;
        repeat (8) @(negedge mclk);
        xfer(1'b0, `STM_ADDR_STATUS, 32'h0);
        chk(r[0], cap_hit(i[1:0], e == 0));
        xfer(1'b0, `STM_ADDR_CMPA, 32'h0);
        chk(r[15:8], cap_hit(i[1:0], e == 0) ? 8'h00 : 8'hFF);
      end
    end
    repeat (300) @(negedge mclk);
    xfer(1'b0, `STM_ADDR_STATUS, 32'h0);
    chk(r[1], 1'b1);
    // Clock enable low for 20 edges leaves 4 counts between the two samples
    xfer(1'b0, `STM_ADDR_COUNT, 32'h0);
    a = r[15:0];
    @(posedge mclk);
    ce <= 1'b0;
    repeat (20) @(posedge mclk);
    ce <= 1'b1;
    xfer(1'b0, `STM_ADDR_COUNT, 32'h0);
    chk(r, {24'h0, 8'(a[7:0] + 8'h04)});
    $display("test capture done");
    wrap_up();
  end
endmodule : stm_core_bench
bind stm_core stm_core_chk chk_i (.MCLK(MCLK), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
  .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .TIMER_PIN_ZERO_OUT(TIMER_PIN_ZERO_OUT), .TIMER_PIN_ZERO_OE(TIMER_PIN_ZERO_OE));
